/* File: common/vbi_pkg.sv */
// Operation
// - Status flags stay set until written one
// - Empty flag bit 6 follows FIFO occupancy
// - Availability flags set per arriving data type, teletext only when stored in FIFO
// - Line not fitting: flag error, drop line
// - Later fitting line accepted despite error flag
// - Word count register reads FIFO occupancy
// - Threshold interrupt when count exceeds threshold
// - Any write to flush register empties FIFO
// - Line interrupt on programmed line, per-field enables
// - Line numbers zero and one never interrupt
// - Mode switch at programmed 10-bit pixel position
// - Host access bit selects I2C or video port
// - Full field mode slices lines outside vblank and FFh table lines
// - Non-FFh line mode overrides full field standard
// - Line mode registers for lines 6..27, both fields
// - Bit 7 enables null or data filtering
// - Bit 6 routes to FIFO; teletext always FIFO
// - Bit 5 keeps errored data out of FIFO
// - Bit 4 enables correction for codes 1..4
// - Bits 3:0 select slicing standard, 1111 off
// - Full field mode register same encoding, 7Fh
// - Each interrupt gated by its own enable bit
package vbi_pkg;
   // I2C slave address, value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2C;
   localparam logic [7:0] OFS_IRQ_EN = 8'hC1;
   localparam logic [7:0] OFS_STATUS = 8'hC6;
   localparam logic [7:0] OFS_WCOUNT = 8'hC7;
   localparam logic [7:0] OFS_THRESH = 8'hC8;
   localparam logic [7:0] OFS_FLUSH = 8'hC9;
   localparam logic [7:0] OFS_LINE_IRQ = 8'hCA;
   localparam logic [7:0] OFS_PIX_LO = 8'hCB;
   localparam logic [7:0] OFS_PIX_HI = 8'hCC;
   localparam logic [7:0] OFS_OUT_SEL = 8'hCD;
   localparam logic [7:0] OFS_FF_EN = 8'hCF;
   localparam logic [7:0] OFS_LMODE0 = 8'hD0;
   localparam logic [7:0] OFS_LMODE_END = 8'hFB;
   localparam logic [7:0] OFS_FF_MODE = 8'hFC;
   localparam logic [7:0] OFS_FIFO_DATA = 8'h80;
   localparam int ST_FULL = 7;
   localparam int ST_EMPTY = 6;
   localparam logic [7:0] ST_CLR_MASK = 8'hBF;
   localparam int LM_FILT = 7;
   localparam int LM_FIFO = 6;
   localparam int LM_ERRBLK = 5;
   localparam int LM_EDC = 4;
   localparam int LI_F1 = 7;
   localparam int LI_F2 = 6;
   localparam int IE_LINE = 0;
   localparam int IE_FIFO = 1;
   localparam int KIND_TTX = 5;
   localparam logic [9:0] FIRST_LINE = 10'h006;
   localparam logic [9:0] LAST_LINE = 10'h01B;
   localparam logic [5:0] MIN_IRQ_LINE = 6'h02;
   localparam logic [3:0] EDC_LO = 4'h1;
   localparam logic [3:0] EDC_HI = 4'h4;
   localparam logic [7:0] MODE_OFF = 8'hFF;
   localparam logic [7:0] THRESH_RST = 8'h80;
   localparam logic [7:0] PIX_LO_RST = 8'h4E;
   localparam logic [7:0] FF_MODE_RST = 8'h7F;
   localparam logic [43:0][7:0] LMODE_RST = {{43{8'hFF}}, 8'h00};
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_SUB, I_WR, I_RD} i2c_e;
   // Header of a sliced line, len counts its data bytes only
   typedef struct packed {
      logic start;
      logic [8:0] len;
      logic [5:0] kind;
      logic err;
   } line_hdr_s;
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } slice_byte_s;
   typedef struct packed {
      logic [9:0] line_num;
      logic field;
      logic vblank;
      logic [9:0] pix;
   } video_time_s;
endpackage : vbi_pkg

/* File: hdl/vbi_slicer_fifo_control.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Word FIFO
// ****************************************
module slice_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fst_s;
   fst_s f_r, f_nxt;
   logic push, pop;
   assign in_ready = f_r.cnt != (AW+1)'(DEPTH);
   assign out_valid = f_r.cnt != '0;
   assign out_data = f_r.mem[f_r.rp];
   assign count = f_r.cnt;
   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;
   // Pointers wrap at DEPTH; flush discards everything held
   always_comb begin
      f_nxt = f_r;
      if (push) begin
         f_nxt.mem[f_r.wp] = in_data;
         f_nxt.wp = (f_r.wp == AW'(DEPTH-1)) ? '0 : f_r.wp + 1'b1;
      end
      if (pop) begin
         f_nxt.rp = (f_r.rp == AW'(DEPTH-1)) ? '0 : f_r.rp + 1'b1;
      end
      f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         f_nxt.wp = '0;
         f_nxt.rp = '0;
         f_nxt.cnt = '0;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         f_r <= '0;
      end else begin
         f_r <= f_nxt;
      end
   end
endmodule : slice_fifo

// ****************************************
// Slicer control and status, I2C register slave
// ****************************************
module vbi_slicer_fifo_control #(
   parameter logic [6:0] DEV_ADDR = vbi_pkg::DEV_ADDR_DEF,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire vbi_pkg::line_hdr_s hdr,
   input wire vbi_pkg::slice_byte_s byt,
   output logic byte_ready,
   input wire vbi_pkg::video_time_s vt,
   output logic [7:0] cur_mode,
   output logic edc_en,
   output logic filter_en,
   output logic fifo_irq,
   output logic line_irq,
   output logic vid_valid,
   output logic [7:0] vid_data
);
   import vbi_pkg::*;
   localparam int CW = $clog2(FIFO_DEPTH) + 1;
   typedef struct packed {
      i2c_e ist;
      logic [3:0] bitcnt;
      logic ack;
      logic nack;
      logic drv;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [7:0] sub;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      logic [7:0] status;
      logic [7:0] thresh;
      logic [7:0] lirq;
      logic [7:0] pix_lo;
      logic [1:0] pix_hi;
      logic host;
      logic ff_en;
      logic [7:0] ff_mode;
      logic [1:0] irq_en;
      logic [43:0][7:0] lmode;
      logic [7:0] cur;
      logic edc;
      logic filt;
      logic take;
      logic [7:0] pend;
      logic pend_v;
      logic [15:0] wq;
      logic wq_v;
      logic pad;
      logic brdy;
      logic bsel;
      logic [7:0] hold;
      logic vhalf;
      logic vv;
      logic [7:0] vd;
      logic fi;
      logic li;
   } st_s;
   st_s r, n;
   logic flush, pop, fin_ready, fvalid;
   logic [15:0] fout;
   logic [CW-1:0] fcount;

   slice_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .flush(flush),
      .in_valid(r.wq_v),
      .in_ready(fin_ready),
      .in_data(r.wq),
      .out_valid(fvalid),
      .out_ready(pop),
      .out_data(fout),
      .count(fcount)
   );

   // Outputs straight from state, sda_out tied low
   assign sda_out = 1'b0;
   assign sda_oe = r.drv;
   assign byte_ready = r.brdy;
   assign cur_mode = r.cur;
   assign edc_en = r.edc;
   assign filter_en = r.filt;
   assign fifo_irq = r.fi;
   assign line_irq = r.li;
   assign vid_valid = r.vv;
   assign vid_data = r.vd;

   // Register read mux
   function automatic logic [7:0] rd_reg(input st_s s,
                                         input logic fv,
                                         input logic [15:0] fo,
                                         input logic [CW-1:0] fc);
      logic [7:0] idx;
      idx = 8'(s.sub - OFS_LMODE0);
      rd_reg = 8'h00;
      if (s.sub >= OFS_LMODE0 && s.sub <= OFS_LMODE_END) begin
         rd_reg = s.lmode[idx[5:0]];
      end else begin
         unique case (s.sub)
            OFS_IRQ_EN: rd_reg = {6'h00, s.irq_en};
            OFS_STATUS: rd_reg = {s.status[7], fc == '0, s.status[5:0]};
            OFS_WCOUNT: rd_reg = 8'(fc);
            OFS_THRESH: rd_reg = s.thresh;
            OFS_LINE_IRQ: rd_reg = s.lirq;
            OFS_PIX_LO: rd_reg = s.pix_lo;
            OFS_PIX_HI: rd_reg = {6'h00, s.pix_hi};
            OFS_OUT_SEL: rd_reg = {7'h00, s.host};
            OFS_FF_EN: rd_reg = {7'h00, s.ff_en};
            OFS_FF_MODE: rd_reg = s.ff_mode;
            OFS_FIFO_DATA: rd_reg = (s.host && fv) ?
                                    (s.bsel ? fo[15:8] : fo[7:0]) : 8'h00;
            default: rd_reg = 8'h00;
         endcase
      end
   endfunction : rd_reg

   // Next-state logic for bus, registers, admission and output
   always_comb begin
      logic rise, fall, start, stop, wr_ev, ld, teletext, freq, blk, fits;
      logic in_tab;
      logic [5:0] lidx;
      logic [7:0] widx, lm, want, set, clr, rdv;
      logic [9:0] need, free, lnum;
      n = r;
      {rise, fall, start, stop, teletext, freq, blk, fits, in_tab} = 9'h000;
      lidx = 6'h00;
      {widx, lm, want, rdv} = 32'h00000000;
      {need, free, lnum} = 30'h00000000;
      flush = 1'b0;
      pop = 1'b0;
      wr_ev = 1'b0;
      ld = 1'b0;
      set = 8'h00;
      clr = 8'h00;
      // Three-flop pin sync; a change counts once flops 2 and 3 agree
      n.scl_s = {r.scl_s[1:0], scl_in};
      n.sda_s = {r.sda_s[1:0], sda_in};
      if (r.scl_s[1] == r.scl_s[2]) n.scl_f = r.scl_s[2];
      if (r.sda_s[1] == r.sda_s[2]) n.sda_f = r.sda_s[2];
      rise = n.scl_f & ~r.scl_f;
      fall = ~n.scl_f & r.scl_f;
      start = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
      stop = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;
      rdv = rd_reg(r, fvalid, fout, fcount);
      // I2C slave; SDA changes only after SCL falls
      if (start) begin
         n.ist = I_ADDR;
         n.bitcnt = 4'h0;
         n.ack = 1'b0;
         n.drv = 1'b0;
      end else if (stop) begin
         n.ist = I_IDLE;
         n.drv = 1'b0;
      end else if (r.ist != I_IDLE) begin
         if (rise && !r.ack) begin
            if (r.ist == I_RD) begin
               if (r.bitcnt == 4'h8) n.nack = n.sda_f;
            end else begin
               n.sh = {r.sh[6:0], n.sda_f};
            end
            n.bitcnt = r.bitcnt + 4'h1;
         end
         if (fall) begin
            if (r.ist == I_RD) begin
               if (r.bitcnt < 4'h8) n.drv = ~r.tx[3'd7 - r.bitcnt[2:0]];
               else if (r.bitcnt == 4'h8) n.drv = 1'b0;
               else if (r.nack) n.ist = I_IDLE;
               else ld = 1'b1;
            end else if (r.ack) begin
               n.ack = 1'b0;
               n.drv = 1'b0;
               n.bitcnt = 4'h0;
               unique case (r.ist)
                  I_ADDR: begin
                     n.ist = r.sh[0] ? I_RD : I_SUB;
                     ld = r.sh[0];
                  end
                  I_SUB: begin
                     n.sub = r.sh;
                     n.ist = I_WR;
                  end
                  I_WR: wr_ev = 1'b1;
                  default: n.ist = I_IDLE;
               endcase
            end else if (r.bitcnt == 4'h8) begin
               if (r.ist == I_ADDR && r.sh[7:1] != DEV_ADDR) begin
                  n.ist = I_IDLE;
               end else begin
                  n.ack = 1'b1;
                  n.drv = 1'b1;
               end
            end
         end
      end
      // Read byte load; FIFO port holds its address, low byte first
      if (ld) begin
         n.bitcnt = 4'h0;
         n.tx = rdv;
         n.drv = ~rdv[7];
         if (r.sub == OFS_FIFO_DATA) begin
            if (r.host && fvalid) begin
               n.bsel = ~r.bsel;
               pop = r.bsel;
            end
         end else begin
            n.sub = r.sub + 8'h01;
         end
      end
      // Register writes, subaddress auto-increments
      widx = 8'(r.sub - OFS_LMODE0);
      if (wr_ev) begin
         n.sub = r.sub + 8'h01;
         if (r.sub >= OFS_LMODE0 && r.sub <= OFS_LMODE_END) begin
            n.lmode[widx[5:0]] = r.sh;
         end
         unique case (r.sub)
            OFS_IRQ_EN: n.irq_en = r.sh[1:0];
            OFS_STATUS: clr = r.sh & ST_CLR_MASK;
            OFS_THRESH: n.thresh = r.sh;
            OFS_FLUSH: flush = 1'b1;
            OFS_LINE_IRQ: n.lirq = r.sh;
            OFS_PIX_LO: n.pix_lo = r.sh;
            OFS_PIX_HI: n.pix_hi = r.sh[1:0];
            OFS_OUT_SEL: n.host = r.sh[0];
            OFS_FF_EN: n.ff_en = r.sh[0];
            OFS_FF_MODE: n.ff_mode = r.sh;
            default: n.irq_en = r.irq_en;
         endcase
      end
      // Standard for the present line
      lnum = 10'(vt.line_num - FIRST_LINE);
      lidx = {lnum[4:0], vt.field};
      in_tab = vt.vblank && vt.line_num >= FIRST_LINE &&
               vt.line_num <= LAST_LINE;
      lm = r.lmode[lidx];
      if (in_tab && lm != MODE_OFF) begin
         want = lm;
      end else if (r.ff_en && (!vt.vblank || in_tab)) begin
         want = r.ff_mode;
      end else begin
         want = MODE_OFF;
      end
      // Reload at the switch pixel, so a line in flight keeps its setup
      if (vt.pix == {r.pix_hi, r.pix_lo}) begin
         n.cur = want;
         n.edc = want[LM_EDC] && want[3:0] >= EDC_LO &&
                 want[3:0] <= EDC_HI;
         n.filt = want[LM_FILT];
      end
      // Word queue drains into the FIFO
      if (r.wq_v && fin_ready) n.wq_v = 1'b0;
      // Whole-line admission against free space
      teletext = hdr.kind[KIND_TTX];
      freq = r.cur[LM_FIFO] | teletext;
      blk = hdr.err & r.cur[LM_ERRBLK];
      need = 10'(({1'b0, hdr.len} + 10'h001) >> 1);
      free = 10'(FIFO_DEPTH) - 10'(fcount) - 10'(r.wq_v);
      fits = need <= free;
      if (hdr.start) begin
         n.take = freq & ~blk & fits;
         set[ST_FULL] = freq & ~blk & ~fits;
         set[5:0] = hdr.kind & {6{~teletext | (freq & ~blk & fits)}};
      end
      // Byte pairing, low byte first; odd tail padded with zero
      if (byt.valid && r.brdy) begin
         if (r.take) begin
            if (!r.pend_v) begin
               n.pend = byt.data;
               n.pend_v = 1'b1;
               n.pad = byt.last;
            end else begin
               n.wq = {byt.data, r.pend};
               n.wq_v = 1'b1;
               n.pend_v = 1'b0;
            end
         end
         if (byt.last) n.take = 1'b0;
      end
      if (r.pad && !n.wq_v) begin
         n.wq = {8'h00, r.pend};
         n.wq_v = 1'b1;
         n.pend_v = 1'b0;
         n.pad = 1'b0;
      end
      if (flush) begin
         n.bsel = 1'b0;
         n.wq_v = 1'b0;
         n.pend_v = 1'b0;
         n.pad = 1'b0;
         n.take = 1'b0;
      end
      // Stall the slicer when both holding stages are occupied or a padded tail waits
      n.brdy = !(n.wq_v && n.pend_v) && !n.pad;
      // Status: a hardware set wins over a host clear
      n.status = (r.status & ~clr) | set;
      // Video port streaming when host access is off
      n.vv = 1'b0;
      if (r.host) begin
         n.vhalf = 1'b0;
      end else if (r.vhalf) begin
         n.vd = r.hold;
         n.vv = 1'b1;
         n.vhalf = 1'b0;
      end else if (fvalid) begin
         pop = 1'b1;
         n.vd = fout[7:0];
         n.hold = fout[15:8];
         n.vhalf = 1'b1;
         n.vv = 1'b1;
      end
      // Interrupt levels
      n.fi = r.irq_en[IE_FIFO] && 8'(fcount) > r.thresh;
      n.li = r.irq_en[IE_LINE] && r.lirq[5:0] >= MIN_IRQ_LINE &&
             vt.line_num == {4'h0, r.lirq[5:0]} &&
             (vt.field ? r.lirq[LI_F2] : r.lirq[LI_F1]);
   end

   // Single state register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.ist <= I_IDLE;
         r.scl_s <= 3'h7;
         r.sda_s <= 3'h7;
         r.scl_f <= 1'b1;
         r.sda_f <= 1'b1;
         r.thresh <= THRESH_RST;
         r.pix_lo <= PIX_LO_RST;
         r.host <= 1'b1;
         r.ff_mode <= FF_MODE_RST;
         r.lmode <= LMODE_RST;
         r.cur <= MODE_OFF;
         r.brdy <= 1'b1;
      end else begin
         r <= n;
      end
   end
endmodule : vbi_slicer_fifo_control
`default_nettype wire

/* File: dv/vbi_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module vbi_sva
   import vbi_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_oe,
   input wire vbi_pkg::video_time_s vt,
   input wire logic [7:0] cur_mode,
   input wire logic edc_en,
   input wire logic filter_en,
   input wire logic line_irq,
   input wire logic vid_valid,
   input wire logic byte_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Low then high byte of one word, back to back
   sequence word_out;
      vid_valid ##1 vid_valid;
   endsequence
   // A fresh mode byte has just been loaded
   sequence new_mode;
      $changed(cur_mode);
   endsequence
   line_low_a: assert property ((vt.line_num < 10'h002) |=> !line_irq)
      else $error("line irq on line zero or one");
   line_range_a: assert property (
      line_irq |-> ($past(vt.line_num) inside {[10'h002:10'h03F]}))
      else $error("line irq outside six bit range");
   // Level only while the same line is present
   line_hold_a: assert property (
      (line_irq && $past(line_irq)) |->
      ($past(vt.line_num) == $past(vt.line_num, 2)))
      else $error("line irq held across lines");
   filter_set_a: assert property (
      new_mode |-> ##[0:1] (filter_en == cur_mode[7]))
      else $error("filter enable not from bit 7");
   edc_set_a: assert property (
      new_mode |-> ##[0:1] (edc_en == (cur_mode[4] &&
      (cur_mode[3:0] inside {[4'h1:4'h4]}))))
      else $error("correction enable wrong");
   vid_pair_a: assert property ($rose(vid_valid) |-> word_out)
      else $error("video word not two bytes");
   // Dropped lines still drain, so the source never hangs
   ready_back_a: assert property (!byte_ready |-> ##[1:8] byte_ready)
      else $error("byte ready stuck low");
   ack_low_a: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data line pulled while clock high");
endmodule : vbi_sva
bind vbi_slicer_fifo_control vbi_sva u_sva (
   .clk(clk), .reset(reset), .scl_in(scl_in), .sda_oe(sda_oe), .vt(vt),
   .cur_mode(cur_mode), .edc_en(edc_en), .filter_en(filter_en),
   .line_irq(line_irq), .vid_valid(vid_valid), .byte_ready(byte_ready));
`default_nettype wire

/* File: dv/i2c_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Host side of the serial register bus
// ****************************************
module i2c_host #(
   parameter logic [6:0] ADDR = 7'h00
) (
   input wire logic clk,
   input wire logic sda_oe,
   output logic scl,
   output wire logic sda
);
   logic pull = 1'b0;
   // Open drain with pull-up: low if any party pulls
   assign sda = ~(pull | sda_oe);
   initial scl = 1'b1;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Data moves mid low phase, never next to a clock edge
   task automatic put(input logic b);
      tick(4);
      pull = ~b;
      tick(4);
      scl = 1'b1;
      tick(8);
      scl = 1'b0;
   endtask : put
   task automatic get(output logic b);
      tick(4);
      pull = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(8);
      b = sda;
      scl = 1'b0;
   endtask : get
   // Release data while clock is low, then pull it low with clock high
   task automatic start();
      tick(4);
      pull = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(8);
      pull = 1'b1;
      tick(8);
      scl = 1'b0;
   endtask : start
   // Data low under a low clock, clock up, then data released
   task automatic stop();
      tick(4);
      pull = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(8);
      pull = 1'b0;
      tick(8);
   endtask : stop
   task automatic wr8(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) put(d[i]);
      get(a);
   endtask : wr8
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      start();
      wr8({ADDR, 1'b0});
      wr8(a);
      wr8(d);
      stop();
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      start();
      wr8({ADDR, 1'b0});
      wr8(a);
      start();
      wr8({ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(1'b1);
      stop();
   endtask : read_reg
endmodule : i2c_host
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Top level bench
// ****************************************
module tb_top;
   import vbi_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic scl, sda_oe, byte_ready, fifo_irq, line_irq, vid_valid;
   logic edc_en, filter_en;
   wire sda;
   line_hdr_s hdr = '0;
   slice_byte_s byt = '0;
   video_time_s vt = '0;
   logic [7:0] cur_mode, vid_data;
   logic [31:0] lfsr = 32'd72725;
   logic [9:0] sw_pix = 10'h04E;
   logic [7:0] sent[$];
   logic [7:0] vq[$];
   logic [7:0] ra[13] = '{8'hC6, 8'hC7, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
      8'hCE, 8'hCF, 8'hD0, 8'hD1, 8'hFB, 8'hFC};
   logic [7:0] rv[13] = '{8'h40, 8'h00, 8'h80, 8'h00, 8'h4E, 8'h00, 8'h01,
      8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h7F};
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   always #10 clk = ~clk;
   i2c_host #(.ADDR(DEV_ADDR_DEF)) host (.clk(clk), .sda_oe(sda_oe),
      .scl(scl), .sda(sda));
   vbi_slicer_fifo_control #(.DEV_ADDR(DEV_ADDR_DEF), .FIFO_DEPTH(16)) dut (
      .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe(sda_oe), .hdr(hdr), .byt(byt), .byte_ready(byte_ready),
      .vt(vt), .cur_mode(cur_mode), .edc_en(edc_en), .filter_en(filter_en),
      .fifo_irq(fifo_irq), .line_irq(line_irq), .vid_valid(vid_valid),
      .vid_data(vid_data));
   // Bytes leaving on the video port
   always @(posedge clk) if (vid_valid === 1'b1) vq.push_back(vid_data);
   // Hang guard, far above the normal run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   // Words taken by a line, odd byte padded
   function automatic logic [7:0] words(input int len);
      return 8'((len + 1) / 2);
   endfunction : words
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic check(input string w, input logic [7:0] s,
      input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", w, e, s);
      end
   endtask : check
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
      logic [7:0] d;
      host.read_reg(a, d);
      check(w, d, e);
   endtask : rc
   // Present a line, pass the switch pixel, let the mode settle
   task automatic go_line(input int ln, input logic f, input logic vb);
      @(posedge clk);
      #1;
      vt = '{10'(ln), f, vb, sw_pix};
      @(posedge clk);
      #1;
      vt.pix = sw_pix + 10'h001;
      repeat (3) @(posedge clk);
      #1;
   endtask : go_line
   task automatic send_line(input int len, input logic [5:0] k, input logic e);
      @(posedge clk);
      #1;
      hdr = '{1'b1, 9'(len), k, e};
      sent.delete();
      @(posedge clk);
      #1;
      hdr.start = 1'b0;
      for (int i = 0; i < len; i++) begin
         lfsr = nxt(lfsr);
         byt = '{1'b1, (i == len - 1), lfsr[7:0]};
         sent.push_back(lfsr[7:0]);
         while (byte_ready !== 1'b1) begin
            @(posedge clk);
            #1;
         end
         @(posedge clk);
         #1;
      end
      byt = '0;
      repeat (6) @(posedge clk);
      #1;
   endtask : send_line
   initial begin
      repeat (16) @(posedge clk);
      #1;
      reset = 1'b0;
      repeat (4) @(posedge clk);
      foreach (ra[i]) rc(ra[i], rv[i], "reset");
      host.write_reg(8'hD2, 8'h67);
      host.write_reg(8'hD3, 8'h93);
      host.write_reg(8'hCB, 8'h10);
      host.write_reg(8'hCC, 8'h01);
      go_line(7, 1'b0, 1'b1);
      check("old pixel", cur_mode, 8'hFF);
      sw_pix = 10'h110;
      go_line(7, 1'b0, 1'b1);
      check("mode f1", cur_mode, 8'h67);
      check("filter", {7'h0, filter_en}, 8'h00);
      check("edc", {7'h0, edc_en}, 8'h00);
      go_line(7, 1'b1, 1'b1);
      check("mode f2", cur_mode, 8'h93);
      check("filter", {7'h0, filter_en}, 8'h01);
      check("edc", {7'h0, edc_en}, 8'h01);
      go_line(30, 1'b0, 1'b0);
      check("no full", cur_mode, 8'hFF);
      host.write_reg(8'hCF, 8'h01);
      host.write_reg(8'hFC, 8'h17);
      go_line(30, 1'b0, 1'b0);
      check("full", cur_mode, 8'h17);
      go_line(9, 1'b1, 1'b1);
      check("full ffh", cur_mode, 8'h17);
      go_line(7, 1'b0, 1'b1);
      check("override", cur_mode, 8'h67);
      host.write_reg(8'hCF, 8'h00);
      // Word pairing and sticky flags
      send_line(3, 6'h10, 1'b0);
      rc(8'hC6, 8'h10, "status");
      rc(8'hC7, words(3), "count");
      for (int i = 0; i < 4; i++) begin
         rc(8'h80, i < 3 ? sent[i] : 8'h00, "data");
      end
      rc(8'hC6, 8'h50, "sticky");
      host.write_reg(8'hC6, 8'h50);
      rc(8'hC6, 8'h40, "cleared");
      send_line(2, 6'h08, 1'b1);
      rc(8'hC7, 8'h00, "err drop");
      for (int k = 0; k < 6; k++) send_line(2, 6'(1 << k), 1'b0);
      rc(8'hC6, 8'h3F, "types");
      rc(8'hC7, 8'h06, "count");
      host.write_reg(8'hC9, 8'hA5);
      rc(8'hC7, 8'h00, "flush");
      host.write_reg(8'hC6, 8'hFF);
      rc(8'hC6, 8'h40, "clear all");
      go_line(6, 1'b0, 1'b1);
      send_line(2, 6'h10, 1'b0);
      rc(8'hC7, 8'h00, "regs only");
      send_line(2, 6'h20, 1'b0);
      rc(8'hC7, 8'h01, "ttx fifo");
      // Overflow: whole line refused, smaller one still fits
      send_line(28, 6'h20, 1'b0);
      send_line(4, 6'h20, 1'b0);
      rc(8'hC6, 8'hB0, "full err");
      rc(8'hC7, 8'h0F, "no part");
      send_line(2, 6'h20, 1'b0);
      rc(8'hC7, 8'h10, "fits");
      host.write_reg(8'hC8, 8'h0E);
      check("irq gated", {7'h0, fifo_irq}, 8'h00);
      host.write_reg(8'hC1, 8'h02);
      check("irq", {7'h0, fifo_irq}, 8'h01);
      host.write_reg(8'hC8, 8'h10);
      check("irq equal", {7'h0, fifo_irq}, 8'h00);
      host.write_reg(8'hC9, 8'h00);
      host.write_reg(8'hCD, 8'h00);
      vq.delete();
      send_line(3, 6'h20, 1'b0);
      repeat (20) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         check("video", vq[i], i < 3 ? sent[i] : 8'h00);
      end
      rc(8'hC7, 8'h00, "drained");
      host.write_reg(8'hCD, 8'h01);
      host.write_reg(8'hCA, 8'h92);
      go_line(18, 1'b0, 1'b1);
      check("line gated", {7'h0, line_irq}, 8'h00);
      host.write_reg(8'hC1, 8'h03);
      check("line irq", {7'h0, line_irq}, 8'h01);
      go_line(18, 1'b1, 1'b1);
      check("field 2", {7'h0, line_irq}, 8'h00);
      go_line(19, 1'b0, 1'b1);
      check("other line", {7'h0, line_irq}, 8'h00);
      host.write_reg(8'hCA, 8'hC1);
      go_line(1, 1'b0, 1'b1);
      check("line one", {7'h0, line_irq}, 8'h00);
      host.write_reg(8'hCA, 8'hC0);
      go_line(0, 1'b1, 1'b1);
      check("line zero", {7'h0, line_irq}, 8'h00);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
